// ===== pcl_pkg.sv
// Package with register offsets, field positions, reset values and states for the control register bank.
package pcl_pkg;
   typedef enum {
      PCL_IDLE,
      PCL_ACTIVE
   } pcl_state_e;

   localparam logic [7:0] PCL_OFS_PWM_CLK      = 8'h03;
   localparam logic [7:0] PCL_OFS_SINK         = 8'h04;
   localparam logic [7:0] PCL_OFS_REG_EN_GOOD  = 8'h05;

   localparam int         PCL_DIM_RATE_LSB     = 3;
   localparam int         PCL_CLK_EN_BIT       = 2;
   localparam int         PCL_OSC_DIV_LSB      = 0;
   localparam int         PCL_REG2_GOOD_BIT    = 5;
   localparam int         PCL_REG1_GOOD_BIT    = 4;
   localparam int         PCL_REG2_EN_BIT      = 1;
   localparam int         PCL_REG1_EN_BIT      = 0;
   localparam int         PCL_SINK_LSB         = 0;

   localparam logic [1:0] PCL_DIM_RATE_RST     = 2'h3;
   localparam logic       PCL_CLK_EN_RST       = 1'h0;
   localparam logic [1:0] PCL_OSC_DIV_RST      = 2'h0;
   localparam logic       PCL_REG_EN_RST       = 1'h0;
   localparam logic [4:0] PCL_SINK_CODE        = 5'h08;

   localparam logic [1:0] PCL_DIV_BY_1         = 2'h0;
   localparam logic [1:0] PCL_DIV_BY_2         = 2'h1;
endpackage

// ===== pcl_clk_div.sv
// Divider that makes the divided clock output from the crystal oscillator.
`timescale 1ns/1ps
module pcl_clk_div (
   input  wire logic       osc_clk_in,
   input  wire logic       enable_in,
   input  wire logic [1:0] div_sel_in,
   output logic            clk_out
);
   logic       en_s1_r;
   logic       en_s2_r;
   logic [1:0] sel_s1_r;
   logic [1:0] sel_s2_r;
   logic [1:0] sel_s3_r;
   logic [1:0] sel_r;
   logic [2:0] cnt_r;
   logic       div_r;

   always_ff @(posedge osc_clk_in) begin
      en_s1_r  <= enable_in;
      en_s2_r  <= en_s1_r;
      sel_s1_r <= div_sel_in;
      sel_s2_r <= sel_s1_r;
      sel_s3_r <= sel_s2_r;
   end

   // The two select bits may cross on different edges, so a code is used only after it held for two edges.
   always_ff @(posedge osc_clk_in) begin
      if (sel_s3_r == sel_s2_r) begin
         sel_r <= sel_s3_r;
      end
   end

   always_ff @(posedge osc_clk_in) begin
      if (!en_s2_r) begin
         cnt_r <= 3'h0;
         div_r <= 1'b0;
      end else begin
         cnt_r <= cnt_r + 3'h1;
         case (sel_r)
            2'h1:    div_r <= ~cnt_r[0];
            2'h2:    div_r <= cnt_r[1];
            2'h3:    div_r <= (cnt_r == 3'h7) ? 1'b0 : ((cnt_r == 3'h3) ? 1'b1 : div_r);
            default: div_r <= 1'b0;
         endcase
      end
   end

   assign clk_out = en_s2_r && ((sel_r == pcl_pkg::PCL_DIV_BY_1) ? osc_clk_in : div_r);

   property p_off_low;
      @(posedge osc_clk_in) !en_s2_r |=> !div_r && !clk_out;
   endproperty
   a_off_low: assert property (p_off_low) else $error("Divided clock not low while disabled.");

   property p_div2_toggles;
      @(posedge osc_clk_in) (en_s2_r && sel_r == pcl_pkg::PCL_DIV_BY_2) ##1
         (en_s2_r && sel_r == pcl_pkg::PCL_DIV_BY_2) |=> (div_r != $past(div_r));
   endproperty
   a_div2_toggles: assert property (p_div2_toggles) else $error("Divide by two output not toggling.");
endmodule

// ===== pcl_regs.sv
// Control and status register bank for dimming rate, clock output and two regulators.
`timescale 1ns/1ps
// How it works
// - Two-bit rate picks dimming PWM frequency, resets 11.
// - Defaults reload whenever undervoltage lockout occurs.
// - Clock output disabled and low when enable 0.
// - Enable forces oscillator; output needs regulator one.
// - Oscillator runs on enable regardless of regulator one.
// - Divider select: by 1, 2, 4, 8; resets 00.
// - Sink current code reads fixed 01000.
// - Power good sets at 95, clears at 90.
// - Bits 5, 4 report good; zero when disabled.
// - Bits 1, 0 enable regulators; reset disabled.
// - Read-only bits ignore writes; writable bits store.
// - Access returns idle on lockout or stop.
module pcl_regs (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       undervoltage_lockout_in,
   input  wire logic       stop_condition_in,
   input  wire logic       ptr_load_in,
   input  wire logic [7:0] ptr_data_in,
   input  wire logic       wr_in,
   input  wire logic [7:0] wr_data_in,
   input  wire logic       rd_in,
   output logic [7:0]      rd_data_out,
   output logic            rd_valid_out,
   input  wire logic       osc_clk_in,
   input  wire logic       reg1_above_rise_in,
   input  wire logic       reg1_below_fall_in,
   input  wire logic       reg2_above_rise_in,
   input  wire logic       reg2_below_fall_in,
   output logic [1:0]      dim_rate_select_out,
   output logic            osc_force_on_out,
   output logic            divided_clock_pin_out,
   output logic [4:0]      led_sink_current_code_out,
   output logic            regulator_one_enable_out,
   output logic            regulator_two_enable_out
);
   pcl_pkg::pcl_state_e state_r;
   logic [7:0]          ptr_r;
   logic [1:0]          dim_rate_r;
   logic                clk_en_r;
   logic [1:0]          osc_div_r;
   logic                reg1_en_r;
   logic                reg2_en_r;
   logic                reg1_good_r;
   logic                reg2_good_r;
   logic                undervoltage_lockout_s1_r;
   logic                undervoltage_lockout_s2_r;
   logic [3:0]          cmp_s1_r;
   logic [3:0]          cmp_s2_r;
   logic                acc_ok;
   logic                wr_ok;
   logic                clk_gate;
   logic [7:0]          rd_mux;

   // Hysteresis update of one power-good flag.
   function automatic logic pg_next(input logic cur, input logic en, input logic above, input logic below);
      logic r;
      r = cur;
      if (!en || below) begin
         r = 1'b0;
      end else if (above) begin
         r = 1'b1;
      end
      return r;
   endfunction

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         undervoltage_lockout_s1_r <= 1'b1;
         undervoltage_lockout_s2_r <= 1'b1;
         cmp_s1_r  <= 4'h0;
         cmp_s2_r  <= 4'h0;
      end else begin
         undervoltage_lockout_s1_r <= undervoltage_lockout_in;
         undervoltage_lockout_s2_r <= undervoltage_lockout_s1_r;
         cmp_s1_r  <= {reg2_below_fall_in, reg2_above_rise_in, reg1_below_fall_in, reg1_above_rise_in};
         cmp_s2_r  <= cmp_s1_r;
      end
   end

   assign acc_ok = (state_r == pcl_pkg::PCL_ACTIVE) && !undervoltage_lockout_s2_r && !stop_condition_in;
   assign wr_ok  = acc_ok && wr_in;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || undervoltage_lockout_s2_r || stop_condition_in) begin
         state_r <= pcl_pkg::PCL_IDLE;
      end else if (ptr_load_in) begin
         state_r <= pcl_pkg::PCL_ACTIVE;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || undervoltage_lockout_s2_r) begin
         ptr_r <= 8'h00;
      end else if (ptr_load_in && !stop_condition_in) begin
         ptr_r <= ptr_data_in;
      end else if (acc_ok && (wr_in || rd_in)) begin
         ptr_r <= ptr_r + 8'h01;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || undervoltage_lockout_s2_r) begin
         dim_rate_r <= pcl_pkg::PCL_DIM_RATE_RST;
         clk_en_r   <= pcl_pkg::PCL_CLK_EN_RST;
         osc_div_r  <= pcl_pkg::PCL_OSC_DIV_RST;
      end else if (wr_ok && ptr_r == pcl_pkg::PCL_OFS_PWM_CLK) begin
         dim_rate_r <= wr_data_in[pcl_pkg::PCL_DIM_RATE_LSB +: 2];
         clk_en_r   <= wr_data_in[pcl_pkg::PCL_CLK_EN_BIT];
         osc_div_r  <= wr_data_in[pcl_pkg::PCL_OSC_DIV_LSB +: 2];
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || undervoltage_lockout_s2_r) begin
         reg1_en_r <= pcl_pkg::PCL_REG_EN_RST;
         reg2_en_r <= pcl_pkg::PCL_REG_EN_RST;
      end else if (wr_ok && ptr_r == pcl_pkg::PCL_OFS_REG_EN_GOOD) begin
         reg1_en_r <= wr_data_in[pcl_pkg::PCL_REG1_EN_BIT];
         reg2_en_r <= wr_data_in[pcl_pkg::PCL_REG2_EN_BIT];
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || undervoltage_lockout_s2_r) begin
         reg1_good_r <= 1'b0;
         reg2_good_r <= 1'b0;
      end else begin
         reg1_good_r <= pg_next(reg1_good_r, reg1_en_r, cmp_s2_r[0], cmp_s2_r[1]);
         reg2_good_r <= pg_next(reg2_good_r, reg2_en_r, cmp_s2_r[2], cmp_s2_r[3]);
      end
   end

   always_comb begin
      rd_mux = 8'h00;
      case (ptr_r)
         pcl_pkg::PCL_OFS_PWM_CLK: begin
            rd_mux[pcl_pkg::PCL_DIM_RATE_LSB +: 2] = dim_rate_r;
            rd_mux[pcl_pkg::PCL_CLK_EN_BIT]        = clk_en_r;
            rd_mux[pcl_pkg::PCL_OSC_DIV_LSB +: 2]  = osc_div_r;
         end
         pcl_pkg::PCL_OFS_SINK: begin
            rd_mux[pcl_pkg::PCL_SINK_LSB +: 5] = pcl_pkg::PCL_SINK_CODE;
         end
         pcl_pkg::PCL_OFS_REG_EN_GOOD: begin
            rd_mux[pcl_pkg::PCL_REG2_GOOD_BIT] = reg2_good_r;
            rd_mux[pcl_pkg::PCL_REG1_GOOD_BIT] = reg1_good_r;
            rd_mux[pcl_pkg::PCL_REG2_EN_BIT]   = reg2_en_r;
            rd_mux[pcl_pkg::PCL_REG1_EN_BIT]   = reg1_en_r;
         end
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rd_data_out  <= 8'h00;
         rd_valid_out <= 1'b0;
      end else begin
         rd_valid_out <= acc_ok && rd_in && !wr_in;
         if (acc_ok && rd_in && !wr_in) begin
            rd_data_out <= rd_mux;
         end
      end
   end

   // Oscillator forced on by the enable bit alone.
   assign osc_force_on_out = clk_en_r;
   // Clock output also needs regulator one.
   assign clk_gate = clk_en_r && reg1_en_r;

   pcl_clk_div u_div (
      .osc_clk_in (osc_clk_in),
      .enable_in  (clk_gate),
      .div_sel_in (osc_div_r),
      .clk_out    (divided_clock_pin_out)
   );

   // Rate select drives the dimming PWM.
   assign dim_rate_select_out       = dim_rate_r;
   assign led_sink_current_code_out = pcl_pkg::PCL_SINK_CODE;
   assign regulator_one_enable_out  = reg1_en_r;
   assign regulator_two_enable_out  = reg2_en_r;

   sequence s_ctrl_write;
      wr_ok && ptr_r == pcl_pkg::PCL_OFS_PWM_CLK;
   endsequence

   sequence s_read_of(logic [7:0] ofs);
      (acc_ok && rd_in && !wr_in && ptr_r == ofs) ##1 rd_valid_out;
   endsequence

   property p_dim_write;
      @(posedge clk_in) disable iff (!rst_n_in) s_ctrl_write |=> dim_rate_r == $past(wr_data_in[4:3]);
   endproperty
   a_dim_write: assert property (p_dim_write) else $error("Rate select did not store write.");

   property p_undervoltage_lockout_reload;
      @(posedge clk_in) disable iff (!rst_n_in) undervoltage_lockout_s2_r |=>
         (dim_rate_r == 2'h3 && !clk_en_r && osc_div_r == 2'h0);
   endproperty
   a_undervoltage_lockout_reload: assert property (p_undervoltage_lockout_reload) else $error("Defaults not reloaded on lockout.");

   property p_force_osc;
      @(posedge clk_in) disable iff (!rst_n_in) s_ctrl_write ##0 wr_data_in[pcl_pkg::PCL_CLK_EN_BIT] |=>
         osc_force_on_out;
   endproperty
   a_force_osc: assert property (p_force_osc) else $error("Oscillator not forced on.");

   property p_sink_read;
      @(posedge clk_in) disable iff (!rst_n_in) s_read_of(pcl_pkg::PCL_OFS_SINK) |-> rd_data_out == 8'h08;
   endproperty
   a_sink_read: assert property (p_sink_read) else $error("Sink code read wrong.");

   property p_good_rise;
      @(posedge clk_in) disable iff (!rst_n_in) $rose(reg1_good_r) |-> $past(cmp_s2_r[0] && !cmp_s2_r[1]);
   endproperty
   a_good_rise: assert property (p_good_rise) else $error("Good set without rising threshold.");

   property p_good_off;
      @(posedge clk_in) disable iff (!rst_n_in) !reg2_en_r |=> !reg2_good_r;
   endproperty
   a_good_off: assert property (p_good_off) else $error("Good bit set while disabled.");

   property p_en_reload;
      @(posedge clk_in) disable iff (!rst_n_in) undervoltage_lockout_s2_r |=> !reg1_en_r && !reg2_en_r;
   endproperty
   a_en_reload: assert property (p_en_reload) else $error("Regulators not disabled on lockout.");

   property p_spare_zero;
      @(posedge clk_in) disable iff (!rst_n_in) s_read_of(pcl_pkg::PCL_OFS_REG_EN_GOOD) |->
         rd_data_out[7:6] == 2'h0 && rd_data_out[3:2] == 2'h0;
   endproperty
   a_spare_zero: assert property (p_spare_zero) else $error("Spare bits read non-zero.");

   property p_stop_idle;
      @(posedge clk_in) disable iff (!rst_n_in) stop_condition_in |=> state_r == pcl_pkg::PCL_IDLE;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("Access not idle after stop.");

   sequence s_en_write;
      wr_ok && ptr_r == pcl_pkg::PCL_OFS_REG_EN_GOOD;
   endsequence

   sequence s_unmapped_read;
      (acc_ok && rd_in && !wr_in && (ptr_r < pcl_pkg::PCL_OFS_PWM_CLK || ptr_r > pcl_pkg::PCL_OFS_REG_EN_GOOD))
         ##1 rd_valid_out;
   endsequence

   property p_clk_en_write;
      @(posedge clk_in) disable iff (!rst_n_in) s_ctrl_write |=> clk_en_r == $past(wr_data_in[2]);
   endproperty
   a_clk_en_write: assert property (p_clk_en_write) else $error("Clock enable did not store write.");

   property p_div_write;
      @(posedge clk_in) disable iff (!rst_n_in) s_ctrl_write |=> osc_div_r == $past(wr_data_in[1:0]);
   endproperty
   a_div_write: assert property (p_div_write) else $error("Divider select did not store write.");

   property p_en_write;
      @(posedge clk_in) disable iff (!rst_n_in) s_en_write |=>
         reg1_en_r == $past(wr_data_in[0]) && reg2_en_r == $past(wr_data_in[1]);
   endproperty
   a_en_write: assert property (p_en_write) else $error("Regulator enables did not store write.");

   property p_ctrl_spare;
      @(posedge clk_in) disable iff (!rst_n_in) s_read_of(pcl_pkg::PCL_OFS_PWM_CLK) |-> rd_data_out[7:5] == 3'h0;
   endproperty
   a_ctrl_spare: assert property (p_ctrl_spare) else $error("Control spare bits read non-zero.");

   property p_unmapped_read;
      @(posedge clk_in) disable iff (!rst_n_in) s_unmapped_read |-> rd_data_out == 8'h00;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped read not zero.");

   property p_good2_rise;
      @(posedge clk_in) disable iff (!rst_n_in) $rose(reg2_good_r) |->
         $past(reg2_en_r && cmp_s2_r[2] && !cmp_s2_r[3]);
   endproperty
   a_good2_rise: assert property (p_good2_rise) else $error("Good two set without rising threshold.");

   property p_good1_fall;
      @(posedge clk_in) disable iff (!rst_n_in) cmp_s2_r[1] |=> !reg1_good_r;
   endproperty
   a_good1_fall: assert property (p_good1_fall) else $error("Good one kept below falling threshold.");

   property p_good_hold;
      @(posedge clk_in) disable iff (!rst_n_in) (reg1_good_r && reg1_en_r && !cmp_s2_r[1] && !undervoltage_lockout_s2_r) |=>
         reg1_good_r;
   endproperty
   a_good_hold: assert property (p_good_hold) else $error("Good one dropped inside hysteresis.");

   property p_lockout_idle;
      @(posedge clk_in) disable iff (!rst_n_in) undervoltage_lockout_s2_r |=> state_r == pcl_pkg::PCL_IDLE;
   endproperty
   a_lockout_idle: assert property (p_lockout_idle) else $error("Access not idle after lockout.");

   property p_idle_no_write;
      @(posedge clk_in) disable iff (!rst_n_in) (state_r == pcl_pkg::PCL_IDLE && !undervoltage_lockout_s2_r) |=>
         $stable(reg1_en_r) && $stable(reg2_en_r) && $stable(clk_en_r);
   endproperty
   a_idle_no_write: assert property (p_idle_no_write) else $error("Register changed while idle.");
endmodule

// ===== pcl_host_model.sv
// Host controller model that drives the register access port of the bank.
`timescale 1ns/1ps
module pcl_host_model (
   input  wire logic       clk_in,
   output logic            ptr_load_out,
   output logic [7:0]      ptr_data_out,
   output logic            wr_out,
   output logic [7:0]      wr_data_out,
   output logic            rd_out,
   output logic            stop_out,
   input  wire logic [7:0] rd_data_in,
   input  wire logic       rd_valid_in
);
   initial begin
      ptr_load_out = 1'b0;
      ptr_data_out = 8'h00;
      wr_out = 1'b0;
      wr_data_out = 8'h00;
      rd_out = 1'b0;
      stop_out = 1'b0;
   end

   // Released address and data lines show the inverse of their last value.
   task automatic access(input logic [7:0] addr, input logic is_wr, input logic [7:0] data, input logic brk,
                         output logic [7:0] rdata, output logic ok);
      @(posedge clk_in);
      #1;
      ptr_load_out = 1'b1;
      ptr_data_out = addr;
      @(posedge clk_in);
      #1;
      ptr_load_out = 1'b0;
      ptr_data_out = ~addr;
      if (brk) begin
         stop_out = 1'b1;
         @(posedge clk_in);
         #1;
         stop_out = 1'b0;
      end
      wr_out = is_wr;
      rd_out = ~is_wr;
      wr_data_out = data;
      @(posedge clk_in);
      #1;
      wr_out = 1'b0;
      rd_out = 1'b0;
      wr_data_out = ~data;
      ok = is_wr;
      rdata = 8'h00;
      for (int n = 0; n < 4 && !ok; n++) begin
         if (rd_valid_in === 1'b1) begin
            rdata = rd_data_in;
            ok = 1'b1;
         end else begin
            @(posedge clk_in);
            #1;
         end
      end
   endtask
endmodule

// ===== pcl_regs_test.sv
// Self-checking bench for the control register bank.
`timescale 1ns/1ps
module pcl_regs_test;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [7:0] exp;
   } pcl_row_s;
   logic       clk_in;
   logic       rst_n_in;
   logic       osc_clk;
   logic       lockout;
   logic       stop;
   logic       ptr_load;
   logic [7:0] ptr_data;
   logic       wr;
   logic [7:0] wr_data;
   logic       rd;
   logic [7:0] rd_data;
   logic       rd_valid;
   logic [3:0] cmp;
   logic [1:0] dim;
   logic       force_on;
   logic       pin;
   logic [4:0] sink;
   logic       reg1_en;
   logic       reg2_en;
   logic [7:0] got;
   int         n_errors;
   int         comparisons;
   int         pin_edges;
   pcl_row_s   rows [6];

   pcl_regs DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .undervoltage_lockout_in(lockout),
      .stop_condition_in(stop), .ptr_load_in(ptr_load), .ptr_data_in(ptr_data), .wr_in(wr),
      .wr_data_in(wr_data), .rd_in(rd), .rd_data_out(rd_data), .rd_valid_out(rd_valid), .osc_clk_in(osc_clk),
      .reg1_above_rise_in(cmp[0]), .reg1_below_fall_in(cmp[1]), .reg2_above_rise_in(cmp[2]),
      .reg2_below_fall_in(cmp[3]), .dim_rate_select_out(dim), .osc_force_on_out(force_on),
      .divided_clock_pin_out(pin), .led_sink_current_code_out(sink), .regulator_one_enable_out(reg1_en),
      .regulator_two_enable_out(reg2_en));
   pcl_host_model host (.clk_in(clk_in), .ptr_load_out(ptr_load), .ptr_data_out(ptr_data), .wr_out(wr),
      .wr_data_out(wr_data), .rd_out(rd), .stop_out(stop), .rd_data_in(rd_data), .rd_valid_in(rd_valid));

   task automatic give_verdict();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d, input logic brk = 1'b0);
      logic [7:0] x;
      logic       ok;
      host.access(a, 1'b1, d, brk, x, ok);
   endtask
   task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
      logic ok;
      host.access(a, 1'b0, 8'h00, 1'b0, got, ok);
      chk("rd_valid_out", 8'h01, {7'h00, ok});
      if (ok !== 1'b1) begin
         give_verdict();
      end
      chk("rd_data_out", exp, got);
   endtask
   // Counts divided clock rising edges over 96 oscillator periods, allowing one edge of phase slack unless zero edges are expected.
   task automatic count_edges(input int exp);
      int e0;
      int d;
      repeat (6) @(posedge clk_in);
      e0 = pin_edges;
      repeat (96) @(posedge osc_clk);
      d = pin_edges - e0;
      if (exp > 0 && (d == exp - 1 || d == exp + 1)) d = exp;
      @(posedge clk_in);
      #1 chk("divided_clock_pin_out edges", 8'(exp), 8'(d));
   endtask

   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   initial begin
      osc_clk = 1'b0;
      forever #20.833 osc_clk = ~osc_clk;
   end
   always @(posedge pin) pin_edges++;
   initial begin
      #4000000;
      n_errors++;
      give_verdict();
   end

   initial begin
      rows = '{'{8'h03, 8'hff, 8'h1f}, '{8'h03, 8'he0, 8'h00}, '{8'h04, 8'hff, 8'h08},
               '{8'h05, 8'hfe, 8'h02}, '{8'h05, 8'h3d, 8'h01}, '{8'h09, 8'hff, 8'h00}};
      n_errors = 0;
      comparisons = 0;
      rst_n_in = 1'b0;
      lockout = 1'b0;
      cmp = 4'h0;
      repeat (12) @(posedge clk_in);
      #1 rst_n_in = 1'b1;
      repeat (4) @(posedge clk_in);
      rreg(8'h03, 8'h18);
      rreg(8'h04, 8'h08);
      rreg(8'h05, 8'h00);
      chk("led_sink_current_code_out", 8'h08, {3'h0, sink});
      chk("regulator_one_enable_out", 8'h00, {7'h00, reg1_en});
      foreach (rows[i]) begin
         wreg(rows[i].addr, rows[i].wdata);
         rreg(rows[i].addr, rows[i].exp);
      end
      for (int c = 0; c < 4; c++) begin
         wreg(8'h03, 8'(c << 3));
         chk("dim_rate_select_out", 8'(c), {6'h00, dim});
      end
      // The rows left regulator one on, so it is switched off before the enable-only case.
      wreg(8'h05, 8'h00);
      wreg(8'h03, 8'h04);
      chk("osc_force_on_out", 8'h01, {7'h00, force_on});
      count_edges(0);
      wreg(8'h05, 8'h01);
      chk("regulator_one_enable_out", 8'h01, {7'h00, reg1_en});
      for (int c = 0; c < 4; c++) begin
         wreg(8'h03, 8'(4 + c));
         count_edges(96 >> c);
      end
      wreg(8'h03, 8'h00);
      count_edges(0);
      chk("divided_clock_pin_out", 8'h00, {7'h00, pin});
      cmp = 4'h5;
      repeat (5) @(posedge clk_in);
      rreg(8'h05, 8'h11);
      wreg(8'h05, 8'h03);
      chk("regulator_two_enable_out", 8'h01, {7'h00, reg2_en});
      repeat (5) @(posedge clk_in);
      rreg(8'h05, 8'h33);
      cmp = 4'h0;
      repeat (5) @(posedge clk_in);
      rreg(8'h05, 8'h33);
      cmp = 4'h2;
      repeat (5) @(posedge clk_in);
      rreg(8'h05, 8'h23);
      wreg(8'h05, 8'h01);
      rreg(8'h05, 8'h01);
      wreg(8'h05, 8'h02, 1'b1);
      rreg(8'h05, 8'h01);
      wreg(8'h03, 8'h07);
      lockout = 1'b1;
      repeat (4) @(posedge clk_in);
      wreg(8'h05, 8'h03);
      lockout = 1'b0;
      repeat (4) @(posedge clk_in);
      rreg(8'h03, 8'h18);
      rreg(8'h05, 8'h00);
      chk("dim_rate_select_out", 8'h03, {6'h00, dim});
      chk("regulator_one_enable_out", 8'h00, {7'h00, reg1_en});
      chk("regulator_two_enable_out", 8'h00, {7'h00, reg2_en});
      give_verdict();
   end
endmodule
